// ### shared/timer_brk_defines.svh
`ifndef TIMER_BRK_DEFINES_SVH
`define TIMER_BRK_DEFINES_SVH

// Byte addresses of the register map.
`define ADDR_CONTROL_ONE   8'h00
`define ADDR_CONTROL_TWO   8'h04
`define ADDR_CHANNEL_CTRL  8'h20
`define ADDR_BREAK_OUT     8'h44
`define ADDR_DMA_BURST     8'h48
`define ADDR_BURST_WINDOW  8'h4C

// Reset values.
`define RST_REG16          16'h0000
`define RST_DMA_BURST      16'h0000
`define RST_BREAK_OUT      16'h0000

// Fields of break_output_control.
`define BO_DTS_MSB         7
`define BO_LOCK_LSB        8
`define BO_LOCK_MSB        9
`define BO_IDLE_OFF        10
`define BO_RUN_OFF         11
`define BO_BRK_EN          12
`define BO_BRK_POL         13
`define BO_AOE             14
`define BO_MOE             15

// Fields of dma_burst_control; bits 7:5 and 15:13 read as zero.
`define DB_BASE_LSB        0
`define DB_BASE_MSB        4
`define DB_LEN_LSB         8
`define DB_LEN_MSB         12
`define DB_WMASK           16'h1F1F

// Fields of the channel control register.
`define CH_EN              0
`define CH_POL             1
`define CH_CEN             2
`define CH_CPOL            3
`define CH_EN_MASK         16'h0005
`define CH_POL_MASK        16'h000A

// Write buffer depth.
`define FIFO_DEPTH         8

`endif

// ### shared/timer_brk_pkg.sv
package timer_brk_pkg;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_BUSY,
		ST_DONE
	} bus_state_type;

	typedef struct packed {
		logic       write;
		logic [2:0] size;
		logic [7:0] addr;
	} bus_req_type;

	typedef struct packed {
		logic [7:0]  addr;
		logic [15:0] data;
	} reg_wr_type;

endpackage

// ### rtl/timer_brk_dma.sv
`timescale 1ns/1ps
`include "timer_brk_defines.svh"

// Synchronous FIFO; DEPTH must be a power of two.
module wr_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = `FIFO_DEPTH
) (
	input  wire logic             clk_sys,
	input  wire logic             srst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW:0]      wr_ptr_q;
	logic [AW:0]      rd_ptr_q;
	wire              push;
	wire              pop;

	// Full when pointers differ only in the wrap bit.
	assign in_ready  = !(wr_ptr_q[AW] != rd_ptr_q[AW] &&
		wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
	assign out_valid = wr_ptr_q != rd_ptr_q;
	assign out_data  = mem_q[rd_ptr_q[AW-1:0]];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// Storage has no reset; only the pointers need one.
	always_ff @(posedge clk_sys) begin
		if (push)
			mem_q[wr_ptr_q[AW-1:0]] <= in_data;
	end

	// Pointer update.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
		end else begin
			wr_ptr_q <= wr_ptr_q + (AW+1)'(push);
			rd_ptr_q <= rd_ptr_q + (AW+1)'(pop);
		end
	end
endmodule

// Operation
// R1: Run off-state bit: disabled, or inactive first.
// R2: Break input acts only when break enabled.
// R3: Break polarity selects active input level.
// R4: Lock level 1 freezes enable, polarity, auto.
// R5: Software waits one clock after polarity write.
// R6: Auto enable sets main enable on update.
// R7: Main enable gates channel outputs by enables.
// R8: Active break clears main output enable.
// R9: Burst base is offset from control one.
// R10: Burst length field plus one transfers.
// R11: Window access redirects to base plus index.
// R12: Word items fill registers; bytes one each.
// R13: Burst control at 0x48, resets to zero.
// R14: Redirect address steps four bytes per register.
// R15: Lock level field writable once after reset.
// R16: Lock level 2 freezes off-state and polarities.
// R17: Burst index wraps to zero after burst.
// R18: Break suppresses automatic set in same cycle.
module timer_brk_dma
	import timer_brk_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        srst,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic      [31:0] hrdata,
	output logic             hresp,
	input  wire logic        break_input,
	input  wire logic        update_event,
	input  wire logic        pwm_ref,
	output logic      [1:0]  channel_out,
	output logic      [1:0]  channel_oe
);
	// Word decode shared by reads and writes.
	function automatic logic is_reg(input logic [7:0] a,
		input logic [7:0] r);
		return a[7:2] == r[7:2];
	endfunction

	bus_state_type state_q;
	bus_state_type state_d;
	bus_req_type   req_q;
	bus_req_type   req_d;
	reg_wr_type    fifo_in;
	reg_wr_type    fifo_out;
	reg_wr_type    wr;
	logic [15:0]   ctrl_one_q;
	logic [15:0]   ctrl_two_q;
	logic [15:0]   chan_ctrl_q;
	logic [15:0]   chan_ctrl_d;
	logic [15:0]   brk_out_q;
	logic [15:0]   brk_out_d;
	logic [15:0]   dma_burst_q;
	logic [4:0]    burst_idx_q;
	logic          lock_written_q;
	logic          brk_meta_q;
	logic          brk_sync_q;
	logic [1:0]    en_prev_q;
	logic [1:0]    out_d;
	logic [1:0]    oe_d;
	logic [15:0]   rd_val;
	logic          fifo_in_ready;
	logic          fifo_out_valid;

	// Bus phase decode.
	wire        bus_start = hsel && htrans[1] && hready;
	wire        busy      = state_q == ST_BUSY;
	wire        req_win   = is_reg(req_q.addr, `ADDR_BURST_WINDOW);
	wire        win_wr    = busy && req_q.write && req_win;
	// Window writes wait for room; every other access waits until the
	// buffer has drained, so reads never see stale register values.
	wire        can_end   = win_wr ? fifo_in_ready : !fifo_out_valid;
	wire        commit    = busy && can_end;
	wire        direct_wr = commit && req_q.write && !req_win;
	wire        drain_rdy = !direct_wr;
	wire        drain     = fifo_out_valid && drain_rdy;
	wire        wr_en     = direct_wr || drain;
	wire        advance   = commit && req_win;

	// Burst redirection.
	wire [4:0]  base      = dma_burst_q[`DB_BASE_MSB:`DB_BASE_LSB]; // [R9]
	wire [4:0]  blen      = dma_burst_q[`DB_LEN_MSB:`DB_LEN_LSB]; // [R10]
	wire [5:0]  burst_wd  = {1'b0, base} + {1'b0, burst_idx_q}; // [R11]
	wire [7:0]  redirect  = `ADDR_CONTROL_ONE + {burst_wd, 2'b00}; // [R14]
	wire [7:0]  rd_addr   = req_win ? redirect : req_q.addr;
	// Byte items take one register each; word items fill a register.
	wire [31:0] lane      = hwdata >> {req_q.addr[1:0], 3'b000};
	wire [15:0] item      = (req_q.size == 3'h0) ?
		{8'h00, lane[7:0]} : hwdata[15:0]; // [R12]

	// Lock and break decode.
	wire [1:0]  lock      = brk_out_q[`BO_LOCK_MSB:`BO_LOCK_LSB];
	wire        lvl1      = lock != 2'h0;
	wire        lvl2      = lock[1];
	wire        brk_act   = brk_out_q[`BO_BRK_EN] && // [R2]
		(brk_sync_q == brk_out_q[`BO_BRK_POL]); // [R3] [R5]
	wire        moe_eff   = brk_out_q[`BO_MOE] && !brk_act; // [R8]

	// Register write port: direct writes or drained window writes.
	assign fifo_in = '{addr: redirect, data: item};
	assign wr      = direct_wr ? reg_wr_type'{addr: req_q.addr, data: item} :
		fifo_out;
	wire   hit_one = wr_en && is_reg(wr.addr, `ADDR_CONTROL_ONE);
	wire   hit_two = wr_en && is_reg(wr.addr, `ADDR_CONTROL_TWO);
	wire   hit_ch  = wr_en && is_reg(wr.addr, `ADDR_CHANNEL_CTRL);
	wire   hit_bo  = wr_en && is_reg(wr.addr, `ADDR_BREAK_OUT);
	wire   hit_db  = wr_en && is_reg(wr.addr, `ADDR_DMA_BURST);

	wr_fifo #(
		.WIDTH ($bits(reg_wr_type)),
		.DEPTH (`FIFO_DEPTH)
	) u_fifo (
		.clk_sys   (clk_sys),
		.srst      (srst),
		.in_valid  (win_wr),
		.in_ready  (fifo_in_ready),
		.in_data   (fifo_in),
		.out_valid (fifo_out_valid),
		.out_ready (drain_rdy),
		.out_data  (fifo_out)
	);

	// Read mux; unmapped words read as zero, window reads return the redirected register.
	always_comb begin
		rd_val = 16'h0000;
		if (is_reg(rd_addr, `ADDR_CONTROL_ONE))
			rd_val = ctrl_one_q;
		else if (is_reg(rd_addr, `ADDR_CONTROL_TWO))
			rd_val = ctrl_two_q;
		else if (is_reg(rd_addr, `ADDR_CHANNEL_CTRL))
			rd_val = chan_ctrl_q;
		else if (is_reg(rd_addr, `ADDR_BREAK_OUT))
			rd_val = brk_out_q;
		else if (is_reg(rd_addr, `ADDR_DMA_BURST))
			rd_val = dma_burst_q;
	end

	// Bus sequencer: every data phase takes at least one wait state,
	// which keeps hrdata and hreadyout straight from flip-flops.
	always_comb begin
		state_d = state_q;
		req_d   = req_q;
		unique case (state_q)
			ST_IDLE, ST_DONE: begin
				state_d = bus_start ? ST_BUSY : ST_IDLE;
				if (bus_start)
					req_d = '{write: hwrite, size: hsize,
						addr: haddr[7:0]};
			end
			ST_BUSY: begin
				if (commit)
					state_d = ST_DONE;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			state_q   <= ST_IDLE;
			req_q     <= '0;
			hreadyout <= 1'b1;
			hrdata    <= 32'h0000_0000;
			hresp     <= 1'b0;
		end else begin
			state_q   <= state_d;
			req_q     <= req_d;
			hreadyout <= state_d != ST_BUSY;
			hresp     <= 1'b0;
			if (commit && !req_q.write)
				hrdata <= {16'h0000, rd_val};
		end
	end

	// Break pin synchroniser; only the second stage is used.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			brk_meta_q <= 1'b0;
			brk_sync_q <= 1'b0;
		end else begin
			brk_meta_q <= break_input;
			brk_sync_q <= brk_meta_q;
		end
	end

	// Channel control: polarities freeze from lock level 2.
	always_comb begin
		chan_ctrl_d = chan_ctrl_q;
		if (hit_ch) begin
			chan_ctrl_d = (chan_ctrl_q & ~`CH_EN_MASK) |
				(wr.data & `CH_EN_MASK);
			if (!lvl2)
				chan_ctrl_d = (chan_ctrl_d & ~`CH_POL_MASK) |
					(wr.data & `CH_POL_MASK); // [R16]
		end
	end

	// Break/output control with lock protection and main enable.
	always_comb begin
		brk_out_d = brk_out_q;
		if (update_event && brk_out_q[`BO_AOE] && !brk_act)
			brk_out_d[`BO_MOE] = 1'b1; // [R6] [R18]
		if (hit_bo) begin
			if (!lvl1) begin
				brk_out_d[`BO_DTS_MSB:0] = wr.data[`BO_DTS_MSB:0];
				brk_out_d[`BO_BRK_EN]    = wr.data[`BO_BRK_EN]; // [R4]
				brk_out_d[`BO_BRK_POL]   = wr.data[`BO_BRK_POL]; // [R4]
				brk_out_d[`BO_AOE]       = wr.data[`BO_AOE]; // [R4]
			end
			if (!lvl2) begin
				brk_out_d[`BO_IDLE_OFF] = wr.data[`BO_IDLE_OFF]; // [R16]
				brk_out_d[`BO_RUN_OFF]  = wr.data[`BO_RUN_OFF]; // [R16]
			end
			if (!lock_written_q)
				brk_out_d[`BO_LOCK_MSB:`BO_LOCK_LSB] =
					wr.data[`BO_LOCK_MSB:`BO_LOCK_LSB]; // [R15]
			brk_out_d[`BO_MOE] = wr.data[`BO_MOE];
		end
		if (brk_act)
			brk_out_d[`BO_MOE] = 1'b0; // [R8] [R18]
	end

	// Register file.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			ctrl_one_q     <= `RST_REG16;
			ctrl_two_q     <= `RST_REG16;
			chan_ctrl_q    <= `RST_REG16;
			brk_out_q      <= `RST_BREAK_OUT;
			dma_burst_q    <= `RST_DMA_BURST; // [R13]
			lock_written_q <= 1'b0;
		end else begin
			if (hit_one)
				ctrl_one_q <= wr.data;
			if (hit_two)
				ctrl_two_q <= wr.data;
			if (hit_db)
				dma_burst_q <= wr.data & `DB_WMASK; // [R13]
			chan_ctrl_q <= chan_ctrl_d;
			brk_out_q   <= brk_out_d;
			if (hit_bo)
				lock_written_q <= 1'b1; // [R15]
		end
	end

	// Burst index steps per window access and wraps after the last.
	always_ff @(posedge clk_sys) begin
		if (srst)
			burst_idx_q <= 5'h00;
		else if (advance)
			burst_idx_q <= (burst_idx_q >= blen) ?
				5'h00 : burst_idx_q + 5'h01; // [R11] [R17]
	end

	// Output stage; index 0 is the main output, 1 the complementary.
	// The break term acts on the outputs in the same cycle that it
	// clears the enable, so the gating does not lag the register.
	for (genvar i = 0; i < 2; i++) begin : g_out
		wire en  = chan_ctrl_q[i == 0 ? `CH_EN : `CH_CEN];
		wire pol = chan_ctrl_q[i == 0 ? `CH_POL : `CH_CPOL];
		wire ref_lvl = (i == 0) ? pwm_ref : !pwm_ref;

		always_comb begin
			out_d[i] = 1'b0;
			oe_d[i]  = 1'b0;
			if (moe_eff) begin
				if (en && (en_prev_q[i] || !brk_out_q[`BO_RUN_OFF])) begin
					out_d[i] = ref_lvl ^ pol; // [R7]
					oe_d[i]  = 1'b1;
				end else if (brk_out_q[`BO_RUN_OFF]) begin
					out_d[i] = pol; // [R1]
					oe_d[i]  = 1'b1;
				end
			end else if (en && brk_out_q[`BO_IDLE_OFF]) begin
				out_d[i] = pol; // [R7]
				oe_d[i]  = 1'b1;
			end
		end

		always_ff @(posedge clk_sys) begin
			if (srst) begin
				en_prev_q[i]   <= 1'b0;
				channel_out[i] <= 1'b0;
				channel_oe[i]  <= 1'b0;
			end else begin
				en_prev_q[i]   <= en;
				channel_out[i] <= out_d[i];
				channel_oe[i]  <= oe_d[i];
			end
		end
	end
endmodule

// ### sim/bus_master_model.sv
`timescale 1ns/1ps
// Single-transfer AHB-Lite master standing in for the CPU and the DMA.
module bus_master_model (
	input  wire logic        clk_sys,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	output logic             hsel,
	output logic      [31:0] haddr,
	output logic      [1:0]  htrans,
	output logic             hwrite,
	output logic      [2:0]  hsize,
	output logic      [31:0] hwdata
);
	logic hung;

	// Idle bus at time zero; only whole words are ever moved.
	initial begin
		hung = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
	end

	// Holds each phase until hready is seen high; bounded so a hang ends.
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [15:0] d, output logic [15:0] q);
		int n;
		n = 0;
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do begin
			@(posedge clk_sys);
			n++;
		end while (!hready && n < 200);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {16'h0, d};
		do begin
			@(posedge clk_sys);
			n++;
		end while (!hready && n < 400);
		q = hrdata[15:0];
		hwdata <= ~{16'h0, d}; // Released data must not look valid.
		hung = hung | (n >= 400);
	endtask
endmodule

// ### sim/timer_brk_dma_assertions.sv
`timescale 1ns/1ps
// Bus timing and reset checks seen from the top ports only.
module timer_brk_dma_checker (
	input wire logic        clk_sys,
	input wire logic        srst,
	input wire logic        hsel,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic [31:0] hrdata,
	input wire logic        hresp,
	input wire logic [1:0]  channel_oe
);
	logic taken;
	logic rd_q;

	assign taken = hsel & htrans[1] & hready;

	// Remembers a read in flight, so a change of hrdata can be traced.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			rd_q <= 1'b0;
		end else if (taken) begin
			rd_q <= !hwrite;
		end else if (hreadyout) begin
			rd_q <= 1'b0;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);

	a_resp_okay: assert property (hresp == 1'b0)
		else $error("hresp left OKAY");
	a_wait_state: assert property (taken |=> !hreadyout)
		else $error("no wait state after request");
	a_ready_bound: assert property (!hreadyout |-> ##[1:40] hreadyout)
		else $error("answer took too long");
	a_ready_idle: assert property (hreadyout && !taken |=> hreadyout)
		else $error("ready dropped while idle");
	a_upper_zero: assert property (hrdata[31:16] == 16'h0000)
		else $error("upper read data not zero");
	a_data_read: assert property ($changed(hrdata) |-> rd_q)
		else $error("read data moved without a read");
	a_data_ready: assert property ($changed(hrdata) |-> $rose(hreadyout))
		else $error("read data moved off the answer");
	a_reset_quiet: assert property ($fell(srst) |-> hreadyout
		&& channel_oe == 2'h0 && hrdata == 32'h0)
		else $error("outputs not quiet after reset");
endmodule

bind timer_brk_dma timer_brk_dma_checker u_chk (
	.clk_sys(clk_sys),
	.srst(srst),
	.hsel(hsel),
	.htrans(htrans),
	.hwrite(hwrite),
	.hready(hready),
	.hreadyout(hreadyout),
	.hrdata(hrdata),
	.hresp(hresp),
	.channel_oe(channel_oe)
);

// ### sim/timer_brk_dma_tb.sv
`timescale 1ns/1ps
`include "timer_brk_defines.svh"
// Drives registers through the master model and watches the pins.
module timer_brk_dma_tb;
	logic        clk_sys;
	logic        srst;
	logic        break_input;
	logic        update_event;
	logic        pwm_ref;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic        hreadyout;
	logic [31:0] hrdata;
	logic        hresp;
	logic [1:0]  channel_out;
	logic [1:0]  channel_oe;
	logic [15:0] q;
	int          mismatches = 0;
	int          n_checks = 0;

	bus_master_model bus (.clk_sys(clk_sys), .hready(hreadyout),
		.hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
	timer_brk_dma DUT (.clk_sys(clk_sys), .srst(srst), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hrdata(hrdata), .hresp(hresp), .break_input(break_input),
		.update_event(update_event), .pwm_ref(pwm_ref),
		.channel_out(channel_out), .channel_oe(channel_oe));

	// Free-running 25 MHz clock.
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	task automatic final_report;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic check(input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// A stuck bus counts as a mismatch and ends the run.
	task automatic op(input logic w, input logic [7:0] a,
		input logic [15:0] d);
		bus.xfer(w, a, d, q);
		if (bus.hung) begin
			mismatches++;
			final_report();
		end
	endtask

	task automatic rd(input logic [7:0] a, input logic [15:0] exp);
		op(1'b0, a, 16'h0000);
		check(exp, q);
	endtask

	// Pins are looked at after the edge's updates have landed; the
	// closing edge puts the next stimulus back on a rising edge.
	task automatic pins_now(input logic [1:0] oe, input logic [1:0] out);
		#1;
		check({14'h0, oe}, {14'h0, channel_oe});
		check({14'h0, out}, {14'h0, channel_out & channel_oe});
		@(posedge clk_sys);
	endtask

	// Lets the output stage settle for a few edges before looking.
	task automatic pins(input logic [1:0] oe, input logic [1:0] out);
		repeat (3) @(posedge clk_sys);
		pins_now(oe, out);
	endtask

	task automatic pulse_update;
		update_event <= 1'b1;
		@(posedge clk_sys);
		update_event <= 1'b0;
		repeat (3) @(posedge clk_sys);
	endtask

	task automatic do_reset;
		srst <= 1'b1;
		repeat (10) @(posedge clk_sys);
		srst <= 1'b0;
		@(posedge clk_sys);
	endtask

	task automatic sc_regs;
		rd(`ADDR_DMA_BURST, 16'h0000);
		op(1'b1, `ADDR_DMA_BURST, 16'hFFFF);
		rd(`ADDR_DMA_BURST, 16'h1F1F);
		rd(8'h10, 16'h0000);
	endtask

	// Eighteen window writes walk the whole burst and then wrap.
	task automatic sc_burst;
		op(1'b1, `ADDR_DMA_BURST, 16'h1100);
		for (int i = 0; i < 18; i++) begin
			op(1'b1, `ADDR_BURST_WINDOW, 16'(i + 1));
		end
		rd(`ADDR_CONTROL_TWO, 16'h0002);
		rd(`ADDR_CHANNEL_CTRL, 16'h0009);
		rd(`ADDR_BREAK_OUT, 16'h0012);
		rd(`ADDR_BURST_WINDOW, 16'h0001);
	endtask

	task automatic sc_outputs;
		op(1'b1, `ADDR_CHANNEL_CTRL, 16'h0001);
		op(1'b1, `ADDR_BREAK_OUT, 16'h4000);
		pins(2'b00, 2'b00);
		pulse_update();
		rd(`ADDR_BREAK_OUT, 16'hC000);
		pwm_ref <= 1'b1;
		pins(2'b01, 2'b01);
		pwm_ref <= 1'b0;
		pins(2'b01, 2'b00);
		pwm_ref <= 1'b1;
		op(1'b1, `ADDR_CHANNEL_CTRL, 16'h0000);
		pins(2'b00, 2'b00);
		op(1'b1, `ADDR_BREAK_OUT, 16'hC800);
		pins(2'b11, 2'b00);
		op(1'b1, `ADDR_CHANNEL_CTRL, 16'h0001);
		pins_now(2'b11, 2'b00);
		break_input <= 1'b0;
		pins(2'b11, 2'b01);
		op(1'b1, `ADDR_BREAK_OUT, 16'hD800);
		pins(2'b00, 2'b00);
		pulse_update();
		rd(`ADDR_BREAK_OUT, 16'h5800);
		break_input <= 1'b1;
		// The released break must clear the synchroniser first.
		repeat (3) @(posedge clk_sys);
		pulse_update();
		rd(`ADDR_BREAK_OUT, 16'hD800);
		op(1'b1, `ADDR_BREAK_OUT, 16'hF800);
		@(posedge clk_sys);
		rd(`ADDR_BREAK_OUT, 16'h7800);
	endtask

	task automatic sc_lock;
		op(1'b1, `ADDR_BREAK_OUT, 16'h5100);
		rd(`ADDR_BREAK_OUT, 16'h5100);
		op(1'b1, `ADDR_BREAK_OUT, 16'h2200);
		rd(`ADDR_BREAK_OUT, 16'h5100);
		op(1'b1, `ADDR_DMA_BURST, 16'h0101);
		op(1'b1, `ADDR_BURST_WINDOW, 16'h5A5A);
		rd(`ADDR_CONTROL_TWO, 16'h5A5A);
		op(1'b1, `ADDR_BURST_WINDOW, 16'h1234);
		rd(`ADDR_BURST_WINDOW, 16'h5A5A);
	endtask

	// Lock level 2 also freezes the off-state bits and polarities.
	task automatic sc_lock_two;
		op(1'b1, `ADDR_BREAK_OUT, 16'h0200);
		op(1'b1, `ADDR_BREAK_OUT, 16'h0C00);
		rd(`ADDR_BREAK_OUT, 16'h0200);
		op(1'b1, `ADDR_CHANNEL_CTRL, 16'h000F);
		rd(`ADDR_CHANNEL_CTRL, 16'h0005);
		pulse_update();
		rd(`ADDR_BREAK_OUT, 16'h0200);
	endtask

	initial begin
		srst = 1'b1;
		break_input = 1'b1;
		update_event = 1'b0;
		pwm_ref = 1'b0;
		do_reset();
		sc_regs();
		sc_burst();
		sc_outputs();
		do_reset();
		sc_lock();
		do_reset();
		sc_lock_two();
		final_report();
	end
endmodule
